// >>> common/quad_pot_pkg.sv
// Purpose: Shared constants for the quad wiper channel decode and control block
// Assumes: 16-bit serial command words, command in the top nibble, address next
// Notes: Code width is the 256-position width; the 128-position variant masks bit 7
package quad_pot_pkg;
	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CODE_W = 8;
	localparam int WORD_W = 16;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;

	// ---------------------------------------------------------------
	// Command word fields
	// ---------------------------------------------------------------
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int BCAST_POS = 3;
	localparam int UPPER_POS = 2;

	// Command codes
	localparam logic [3:0] CMD_WRITE_WIPER = 4'h1;
	localparam logic [3:0] CMD_WRITE_INPUT = 4'h2;
	localparam logic [3:0] CMD_COPY_INPUT = 4'h6;
	localparam logic [3:0] CMD_COPY_NVM = 4'h7;
	localparam logic [3:0] CMD_WRITE_NVM = 4'h8;
	localparam logic [3:0] CMD_SOFT_RESET = 4'hB;
	localparam logic [3:0] CMD_WRITE_CTRL = 4'hD;

	// ---------------------------------------------------------------
	// Control register fields and reset value
	// ---------------------------------------------------------------
	localparam int WWE_POS = 0;
	localparam int PGM_POS = 1;
	localparam int LIN_POS = 2;
	localparam int BURST_POS = 3;
	localparam logic [3:0] CTRL_RESET = 4'h3;

	// Code ranges and stored memory reset value
	localparam logic [CODE_W-1:0] CODE_MAX_128 = 8'h7F;
	localparam logic [CODE_W-1:0] CODE_MAX_256 = 8'hFF;
	localparam logic [CODE_W-1:0] NVM_RESET = 8'h80;

	typedef enum logic [0:0] {ST_PRESET, ST_RUN} state_type;
endpackage : quad_pot_pkg

// >>> verilog/sync_two_ff.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain
// Assumes: Inputs are slow against clk_sys
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] stable_ff;
	logic [WIDTH-1:0] nxt_stable;

	// Next values of both stages
	always_comb
	begin
		nxt_meta = asyncIn;
		nxt_stable = meta_ff;
	end

	// Stage registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			meta_ff <= '0;
			stable_ff <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			stable_ff <= nxt_stable;
		end
	end

	assign syncOut = stable_ff;
endmodule : sync_two_ff

// >>> verilog/quad_pot_channel_decode_ctrl.sv
// Purpose: Serial command decode, channel addressing and control register
// Assumes: Link clock, data and frame pins are asynchronous to clk_sys
// Notes: Data shifts in MSB first on link clock rising edges while frame is high
`timescale 1ns/100ps
// Summary of operation
// - Top address bit set writes input and wiper registers of every channel.
// - Top two address bits clear; low two bits pick channel one to four.
// - Upper section address only valid in linear gain mode, never for memory.
// - Control bit zero low freezes lower wipers at stored value; high allows writes.
// - Control bit one low blocks stored memory programming; high permits it.
// - Control bit two selects potentiometer mode or linear gain mode.
// - Control bit three enables burst; frame ends do not cancel it.
// - Wiper codes span 0x00-0x7F or 0x00-0xFF by variant.
// - Potentiometer mode upper setting is the complement of the wiper code.
// - Linear gain mode upper setting follows its own wiper register.
// - Power-on preset loads each stored memory value into its wiper.
module quad_pot_channel_decode_ctrl
	import quad_pot_pkg::*;
#(
	parameter bit POS128 = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic linkData,
	input wire logic linkFrame,
	output logic [quad_pot_pkg::NUM_CH*quad_pot_pkg::CODE_W-1:0] lowerCode,
	output logic [quad_pot_pkg::NUM_CH*quad_pot_pkg::CODE_W-1:0] upperCode,
	output logic [3:0] controlConfig,
	output logic presetBusy
);
	import quad_pot_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	logic [2:0] pinSync;
	logic lnkClkS;
	logic lnkDatS;
	logic lnkFrmS;

	sync_two_ff #(.WIDTH(3)) pinSyncInst (
		.clk_sys(clk_sys),
		.rst(rst),
		.asyncIn({linkFrame, linkData, linkClk}),
		.syncOut(pinSync)
	);
	assign lnkClkS = pinSync[0];
	assign lnkDatS = pinSync[1];
	assign lnkFrmS = pinSync[2];

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	state_type state_ff, nxt_state;
	logic clkPrev_ff, nxt_clkPrev;
	logic [WORD_W-2:0] shift_ff, nxt_shift;
	logic [CNT_W-1:0] bitCnt_ff, nxt_bitCnt;
	logic firstDone_ff, nxt_firstDone;
	logic [3:0] ctrl_ff, nxt_ctrl;
	logic [CODE_W-1:0] inLow_ff [NUM_CH], nxt_inLow [NUM_CH];
	logic [CODE_W-1:0] inUp_ff [NUM_CH], nxt_inUp [NUM_CH];
	logic [CODE_W-1:0] wipLow_ff [NUM_CH], nxt_wipLow [NUM_CH];
	logic [CODE_W-1:0] wipUp_ff [NUM_CH], nxt_wipUp [NUM_CH];
	logic [CODE_W-1:0] nvm_ff [NUM_CH], nxt_nvm [NUM_CH];
	logic [NUM_CH*CODE_W-1:0] lowOut_ff, nxt_lowOut;
	logic [NUM_CH*CODE_W-1:0] upOut_ff, nxt_upOut;
	logic busy_ff, nxt_busy;

	// Decoded word
	logic [WORD_W-1:0] word;
	logic wordDone;
	logic exec;
	logic [3:0] cmd;
	logic [3:0] addr;
	logic [CODE_W-1:0] codeMask;
	logic [CODE_W-1:0] data;
	logic bcast;
	logic upper;
	logic linGain;
	logic wwe;
	logic pgm;
	logic nvmOk;

	assign codeMask = POS128 ? CODE_MAX_128 : CODE_MAX_256;
	assign word = {shift_ff, lnkDatS};
	assign wordDone = lnkClkS & ~clkPrev_ff & lnkFrmS & (bitCnt_ff == LAST_BIT);
	assign exec = wordDone & (ctrl_ff[BURST_POS] | ~firstDone_ff) & (state_ff == ST_RUN);
	assign cmd = word[CMD_MSB:CMD_LSB];
	assign addr = word[ADDR_MSB:ADDR_LSB];
	assign data = word[DATA_MSB:0] & codeMask;
	assign bcast = addr[BCAST_POS];
	assign upper = addr[UPPER_POS];
	assign linGain = ctrl_ff[LIN_POS];
	assign wwe = ctrl_ff[WWE_POS];
	assign pgm = ctrl_ff[PGM_POS];
	assign nvmOk = ~bcast & ~upper;

	// ---------------------------------------------------------------
	// Shifter, command execution, preset and output staging
	// ---------------------------------------------------------------
	always_comb
	begin
		logic hit;
		logic selLow;
		logic selUp;
		hit = 1'b0;
		selLow = 1'b0;
		selUp = 1'b0;
		nxt_state = state_ff;
		nxt_clkPrev = lnkClkS;
		nxt_shift = shift_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_firstDone = firstDone_ff;
		nxt_ctrl = ctrl_ff;
		nxt_inLow = inLow_ff;
		nxt_inUp = inUp_ff;
		nxt_wipLow = wipLow_ff;
		nxt_wipUp = wipUp_ff;
		nxt_nvm = nvm_ff;
		if (!lnkFrmS)
		begin
			nxt_bitCnt = '0;
			nxt_firstDone = 1'b0;
		end
		else if (lnkClkS && !clkPrev_ff)
		begin
			nxt_shift = word[WORD_W-2:0];
			nxt_bitCnt = bitCnt_ff + 4'h1;
			if (wordDone)
				nxt_firstDone = 1'b1;
		end
		if (exec)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				hit = bcast | (addr[1:0] == i[1:0]);
				selLow = hit & (bcast | ~upper);
				selUp = hit & linGain & (bcast | upper);
				case (cmd)
					CMD_WRITE_WIPER:
					begin
						if (selLow && wwe)
							nxt_wipLow[i] = data;
						if (selUp && wwe)
							nxt_wipUp[i] = data;
					end
					CMD_WRITE_INPUT:
					begin
						if (selLow)
							nxt_inLow[i] = data;
						if (selUp)
							nxt_inUp[i] = data;
					end
					CMD_COPY_INPUT:
					begin
						if (selLow && wwe)
							nxt_wipLow[i] = inLow_ff[i];
						if (selUp && wwe)
							nxt_wipUp[i] = inUp_ff[i];
					end
					CMD_COPY_NVM:
					begin
						if (hit && nvmOk && data[0] && pgm)
							nxt_nvm[i] = wipLow_ff[i];
						if (hit && nvmOk && !data[0] && wwe)
							nxt_wipLow[i] = nvm_ff[i];
					end
					CMD_WRITE_NVM:
					begin
						if (hit && nvmOk && pgm)
							nxt_nvm[i] = data;
					end
					default:
					begin
					end
				endcase
			end
			if (cmd == CMD_WRITE_CTRL)
				nxt_ctrl = word[3:0];
			if (cmd == CMD_SOFT_RESET)
			begin
				nxt_ctrl = CTRL_RESET;
				nxt_state = ST_PRESET;
			end
		end
		case (state_ff)
			ST_PRESET:
			begin
				nxt_wipLow = nvm_ff;
				nxt_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (!wwe)
					nxt_wipLow = nvm_ff;
			end
			default:
				nxt_state = ST_PRESET;
		endcase
		nxt_busy = (nxt_state == ST_PRESET);
		for (int i = 0; i < NUM_CH; i++)
		begin
			nxt_lowOut[i*CODE_W +: CODE_W] = wipLow_ff[i];
			if (linGain)
				nxt_upOut[i*CODE_W +: CODE_W] = wipUp_ff[i];
			else
				nxt_upOut[i*CODE_W +: CODE_W] = ~wipLow_ff[i] & codeMask;
		end
	end

	// Registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_ff <= ST_PRESET;
			clkPrev_ff <= 1'b0;
			shift_ff <= '0;
			bitCnt_ff <= '0;
			firstDone_ff <= 1'b0;
			ctrl_ff <= CTRL_RESET;
			for (int i = 0; i < NUM_CH; i++)
			begin
				inLow_ff[i] <= '0;
				inUp_ff[i] <= '0;
				wipLow_ff[i] <= '0;
				wipUp_ff[i] <= '0;
				nvm_ff[i] <= NVM_RESET & codeMask;
			end
			lowOut_ff <= '0;
			upOut_ff <= '0;
			busy_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			clkPrev_ff <= nxt_clkPrev;
			shift_ff <= nxt_shift;
			bitCnt_ff <= nxt_bitCnt;
			firstDone_ff <= nxt_firstDone;
			ctrl_ff <= nxt_ctrl;
			inLow_ff <= nxt_inLow;
			inUp_ff <= nxt_inUp;
			wipLow_ff <= nxt_wipLow;
			wipUp_ff <= nxt_wipUp;
			nvm_ff <= nxt_nvm;
			lowOut_ff <= nxt_lowOut;
			upOut_ff <= nxt_upOut;
			busy_ff <= nxt_busy;
		end
	end

	assign lowerCode = lowOut_ff;
	assign upperCode = upOut_ff;
	assign controlConfig = ctrl_ff;
	assign presetBusy = busy_ff;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence execCmd(logic [3:0] c);
		exec && cmd == c;
	endsequence

	bcast_write_a: assert property (execCmd(CMD_WRITE_WIPER) and (bcast && wwe) |=>
		wipLow_ff[0] == $past(data) && wipLow_ff[3] == $past(data))
		else $error("broadcast write missed a channel");
	chan_select_a: assert property (execCmd(CMD_WRITE_WIPER) and (addr == 4'h1 && wwe) |=>
		wipLow_ff[1] == $past(data) && $stable(wipUp_ff[1]))
		else $error("channel select wrote wrong register");
	upper_pot_a: assert property (execCmd(CMD_WRITE_WIPER) and (addr == 4'h5 && !linGain) |=>
		$stable(wipUp_ff[1]))
		else $error("upper section written in potentiometer mode");
	wiper_freeze_a: assert property (!wwe && state_ff == ST_RUN |=>
		wipLow_ff[2] == $past(nvm_ff[2]))
		else $error("wiper not frozen at stored value");
	nvm_block_a: assert property (!pgm |=> $stable(nvm_ff[0]) && $stable(nvm_ff[3]))
		else $error("stored memory changed while blocked");
	ctrl_write_a: assert property (execCmd(CMD_WRITE_CTRL) |=>
		ctrl_ff == $past(word[3:0]) ##1 ctrl_ff == $past(ctrl_ff) || exec || $past(exec))
		else $error("control register write lost");
	burst_hold_a: assert property (ctrl_ff[BURST_POS] && !exec |=> ctrl_ff[BURST_POS])
		else $error("burst cleared without command");
	code_range_a: assert property (POS128 |-> !wipLow_ff[1][7] && !wipUp_ff[1][7])
		else $error("wiper code beyond range");
	upper_cmpl_a: assert property (!linGain |=>
		upOut_ff[7:0] == (~$past(wipLow_ff[0]) & codeMask))
		else $error("upper section not complement");
	upper_lin_a: assert property (linGain |=> upOut_ff[15:8] == $past(wipUp_ff[1]))
		else $error("upper section not own code");
	preset_load_a: assert property (state_ff == ST_PRESET |=>
		state_ff == ST_RUN && wipLow_ff[3] == $past(nvm_ff[3]) ##1 lowerCode[31:24] == $past(wipLow_ff[3]))
		else $error("preset did not load stored value");
	soft_reset_a: assert property (execCmd(CMD_SOFT_RESET) |=> ctrl_ff == CTRL_RESET && presetBusy)
		else $error("software reset did not restore control");
endmodule : quad_pot_channel_decode_ctrl

// >>> dv/link_host_model.sv
// Purpose: Serial host model driving framed 16-bit command words
// Assumes: Link clock period 125 ns, MSB first
// Notes: Clock still between frames; data line toggles once released
`timescale 1ns/100ps
module link_host_model (
	output logic linkClk,
	output logic linkData,
	output logic linkFrame
);
	// --------------------
	// Idle levels
	// --------------------
	initial
	begin
		linkClk = 1'b0;
		linkData = 1'b0;
		linkFrame = 1'b0;
	end

	// Send n words, first word in the upper half
	task automatic send(input logic [31:0] words, input int n);
		logic [15:0] w;
		w = words[31:16];
		linkFrame = 1'b1;
		// Odd lead-in keeps every pin edge off the clk_sys rises
		#61;
		for (int k = 0; k < n; k++)
		begin
			for (int b = 15; b >= 0; b--)
			begin
				linkData = w[b];
				#62.5 linkClk = 1'b1;
				#62.5 linkClk = 1'b0;
			end
			w = words[15:0];
		end
		#62.5 linkFrame = 1'b0;
		linkData = ~linkData; // No stale bit on a released line
	endtask : send
endmodule : link_host_model

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for channel decode and control register
// Assumes: Host model drives the link pins
// Notes: Expected lower codes tracked in expLow
`timescale 1ns/100ps
module tb_top;
	import quad_pot_pkg::*;
	logic clk_sys;
	logic rst;
	logic linkClk;
	logic linkData;
	logic linkFrame;
	logic presetBusy;
	logic [3:0] controlConfig;
	logic [31:0] lowerCode;
	logic [31:0] upperCode;
	logic [31:0] expLow;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;

	// --------------------
	// Instances and clock
	// --------------------
	quad_pot_channel_decode_ctrl u_quad_pot_channel_decode_ctrl (
		.clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .linkData(linkData),
		.linkFrame(linkFrame), .lowerCode(lowerCode), .upperCode(upperCode),
		.controlConfig(controlConfig), .presetBusy(presetBusy));
	link_host_model u_link_host_model (.linkClk(linkClk), .linkData(linkData),
		.linkFrame(linkFrame));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			final_report();
		end
	end

	// --------------------
	// Helpers
	// --------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic codes(input logic [31:0] up);
		chk("lowerCode", expLow, lowerCode);
		chk("upperCode", up, upperCode);
	endtask : codes

	task automatic ctl(input logic [3:0] v);
		chk("controlConfig", {28'h000_0000, v}, {28'h000_0000, controlConfig});
	endtask : ctl

	task automatic run(input logic [31:0] words, input int n);
		@(negedge clk_sys);
		u_link_host_model.send(words, n);
		repeat (6) @(negedge clk_sys);
	endtask : run

	task automatic one(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
		run({c, a, d, 16'h0000}, 1);
	endtask : one

	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// --------------------
	// Scenarios
	// --------------------
	task automatic test_reset;
		chk("presetBusy", 32'h0000_0001, {31'h0, presetBusy});
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		expLow = 32'h8080_8080;
		chk("presetBusy", 32'h0000_0000, {31'h0, presetBusy});
		ctl(4'h3);
		codes(~expLow);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_addr;
		logic [7:0] v[4];
		v = '{8'h00, 8'hFF, 8'h7F, 8'h5A};
		for (int c = 0; c < 4; c++)
		begin
			one(CMD_WRITE_WIPER, 4'(c), v[c]);
			expLow[8*c +: 8] = v[c];
			codes(~expLow);
		end
		one(CMD_WRITE_WIPER, 4'hC, 8'hC3);
		expLow = 32'hC3C3_C3C3;
		codes(~expLow);
		one(CMD_WRITE_WIPER, 4'h5, 8'h11);
		codes(~expLow);
		$display("test_addr done");
	endtask : test_addr

	task automatic test_linear;
		one(CMD_WRITE_CTRL, 4'h0, 8'h07);
		ctl(4'h7);
		one(CMD_WRITE_WIPER, 4'h8, 8'h5A);
		expLow = 32'h5A5A_5A5A;
		codes(32'h5A5A_5A5A);
		one(CMD_WRITE_WIPER, 4'h5, 8'h33);
		codes(32'h5A5A_335A);
		one(CMD_WRITE_WIPER, 4'h2, 8'h44);
		expLow = 32'h5A44_5A5A;
		codes(32'h5A5A_335A);
		$display("test_linear done");
	endtask : test_linear

	task automatic test_protect;
		one(CMD_WRITE_CTRL, 4'h0, 8'h02);
		one(CMD_WRITE_WIPER, 4'h0, 8'h12);
		expLow = 32'h8080_8080;
		codes(~expLow);
		one(CMD_WRITE_CTRL, 4'h0, 8'h01);
		one(CMD_WRITE_NVM, 4'h0, 8'h11);
		one(CMD_COPY_NVM, 4'h0, 8'h00);
		codes(~expLow);
		one(CMD_WRITE_CTRL, 4'h0, 8'h03);
		one(CMD_WRITE_NVM, 4'h0, 8'h22);
		one(CMD_COPY_NVM, 4'h0, 8'h00);
		expLow = 32'h8080_8022;
		codes(~expLow);
		$display("test_protect done");
	endtask : test_protect

	task automatic test_burst;
		run({CMD_WRITE_WIPER, 4'h0, 8'h01, CMD_WRITE_WIPER, 4'h1, 8'h02}, 2);
		expLow = 32'h8080_8001;
		codes(~expLow);
		one(CMD_WRITE_CTRL, 4'h0, 8'h0B);
		ctl(4'hB);
		run({CMD_WRITE_WIPER, 4'h0, 8'h03, CMD_WRITE_WIPER, 4'h1, 8'h04}, 2);
		expLow = 32'h8080_0403;
		codes(~expLow);
		one(CMD_SOFT_RESET, 4'h0, 8'h00);
		expLow = 32'h8080_8022;
		ctl(4'h3);
		codes(~expLow);
		$display("test_burst done");
	endtask : test_burst

	task automatic test_input;
		one(CMD_WRITE_INPUT, 4'h3, 8'h6C);
		codes(~expLow);
		one(CMD_COPY_INPUT, 4'h3, 8'h00);
		expLow[31:24] = 8'h6C;
		codes(~expLow);
		$display("test_input done");
	endtask : test_input

	// Main sequence
	initial
	begin
		rst = 1'b1;
		expLow = 32'h0000_0000;
		repeat (12) @(negedge clk_sys);
		test_reset();
		test_addr();
		test_linear();
		test_protect();
		test_burst();
		test_input();
		final_report();
	end
endmodule : tb_top
